// ===== inc/dma_pkg.sv
package dma_pkg;

  // -----------------------------------------------------------------
  // sizes and address space
  // -----------------------------------------------------------------
  localparam int NUM_CH   = 6;
  localparam int TRIG_NUM = 63;
  localparam int CH_SHIFT = 5;                      // log2 of the channel stride
  localparam logic [15:0] RAM_START  = 16'h0800;    // first address above the sfr region
  localparam logic [15:0] STEP_BYTE  = 16'h0001;
  localparam logic [15:0] STEP_WORD  = 16'h0002;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] LIM_HI_RST = 16'hFFFF;
  localparam logic [15:0] LIM_LO_RST = 16'h0800;
  localparam logic [1:0]  LANE_LO    = 2'h1;
  localparam logic [1:0]  LANE_HI    = 2'h2;
  localparam logic [1:0]  LANE_BOTH  = 2'h3;

  // -----------------------------------------------------------------
  // register map, byte addresses and word index inside a channel
  // -----------------------------------------------------------------
  localparam logic [11:0] OFS_LIM_HI  = 12'h000;
  localparam logic [11:0] OFS_LIM_LO  = 12'h004;
  localparam logic [11:0] OFS_STATUS  = 12'h008;
  localparam logic [11:0] OFS_ACTIVE  = 12'h00C;
  localparam logic [11:0] OFS_CH_BASE = 12'h020;
  localparam logic [11:0] OFS_CH_END  = 12'h0E0;
  localparam logic [2:0]  SUB_CTRL    = 3'h0;
  localparam logic [2:0]  SUB_TRIG    = 3'h1;
  localparam logic [2:0]  SUB_SRC     = 3'h2;
  localparam logic [2:0]  SUB_DST     = 3'h3;
  localparam logic [2:0]  SUB_CNT     = 3'h4;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CTL_REQ   = 8;
  localparam int STAT_DONE = 0;
  localparam int STAT_HALF = 8;
  localparam int STAT_ERR  = 16;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    XFER_ONE = 2'h0, XFER_REP_ONE = 2'h1, XFER_CONT = 2'h2, XFER_REP_CONT = 2'h3
  } xfer_mode_t;

  typedef enum logic [1:0] {
    ADDR_FIXED = 2'h0, ADDR_INC = 2'h1, ADDR_DEC = 2'h2, ADDR_PERI = 2'h3
  } addr_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_READ = 3'h1, ST_RDWAIT = 3'h2, ST_CAPT = 3'h3,
    ST_WRITE = 3'h4, ST_NULL = 3'h5, ST_UPD = 3'h6
  } eng_state_t;

  typedef struct packed {
    logic       nullWr;
    logic       reload;
    addr_mode_t srcMode;
    addr_mode_t dstMode;
    xfer_mode_t xferMode;
    logic       byteSize;
    logic       enable;
  } chan_ctrl_t;

  typedef struct packed {
    chan_ctrl_t  ctrl;
    logic        pend;
    logic [5:0]  trig;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] cnt;
    logic [15:0] srcInit;
    logic [15:0] dstInit;
    logic [15:0] cntInit;
  } chan_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wrData;
    logic [1:0]  byteEn;
    logic        rd;
    logic        wr;
  } bus_req_t;

  typedef struct packed {
    chan_t [NUM_CH-1:0] ch;
    logic [15:0]        limHi;
    logic [15:0]        limLo;
    logic [NUM_CH-1:0]  doneFlag;
    logic [NUM_CH-1:0]  halfFlag;
    logic [NUM_CH-1:0]  errFlag;
    eng_state_t         st;
    logic [2:0]         act;
    logic [15:0]        data;
    bus_req_t           bus;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [NUM_CH-1:0]  doneEvt;
    logic [NUM_CH-1:0]  halfEvt;
    logic               limitEvt;
  } dma_state_t;

endpackage

// ===== logic/dma_addr_unit.sv
`timescale 1ns/100ps
module dma_addr_unit (
  // channel address setup
  input  wire logic [15:0]         base,
  input  dma_pkg::addr_mode_t      mode,
  input  wire logic                byteSize,
  input  wire logic [15:0]         offset,
  // protected window
  input  wire logic [15:0]         limLo,
  input  wire logic [15:0]         limHi,
  // results
  output logic      [15:0]         effAddr,
  output logic      [15:0]         nextAddr,
  output logic                     fault
);

  logic [15:0] step;

  // -----------------------------------------------------------------
  // effective address, step and window check
  // -----------------------------------------------------------------
  // peripheral supplies the offset, the channel only the base
  assign effAddr = (mode == dma_pkg::ADDR_PERI) ? 16'(base + offset) : base; // R15
  assign step    = byteSize ? dma_pkg::STEP_BYTE : dma_pkg::STEP_WORD;

  // indirect and fixed leave the base alone
  always_comb begin
    unique case (mode)
      dma_pkg::ADDR_INC: nextAddr = 16'(base + step); // R14
      dma_pkg::ADDR_DEC: nextAddr = 16'(base - step); // R14
      default:           nextAddr = base;
    endcase
  end

  // sfr region is never fenced, only ram above it
  assign fault = (effAddr >= dma_pkg::RAM_START)
               && ((effAddr < limLo) || (effAddr > limHi)); // R04

endmodule // dma_addr_unit

// ===== logic/dma_controller.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Function
// R01: six channels, each with its own setup, all live at once.
// R02: engine masters the peripheral bus and yields whenever the cpu needs it.
// R03: sfr region and ram region usable as source or destination, any direction.
// R04: ram accesses outside the limits end the transaction and raise an event.
// R05: bit 1 of channel control picks byte or word; word after reset.
// R06: in byte transfers address bit 0 picks upper or lower byte lane.
// R07: one of 63 trigger sources, numbered against natural interrupt priority.
// R08: trigger independent of addresses; channel completion can trigger another channel.
// R09: one-shot mode does one transaction per trigger.
// R10: continuous mode runs back-to-back transactions until the counter empties.
// R11: repeated one-shot does one transaction per trigger until disabled.
// R12: repeated continuous runs a full counted series per trigger until disabled.
// R13: optional reload of addresses and count at completion; repeated modes always.
// R14: fixed or block addressing, blocks increment or decrement per transfer.
// R15: indirect mode adds a peripheral offset to the channel base address.
// R16: several requesting channels are served by fixed channel priority.
// R17: 16-bit source and destination registers, live and reloadable.
// R18: 16-bit transaction count register, live and reloadable.
// R19: event when the count reaches half of its loaded value.
// R20: software request starts a channel without a hardware trigger.
// R21: null-write mode adds a dummy write to the source address.
// R22: upper and lower limit registers bound the protected ram window.
module dma_controller (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // apb register port
  input  wire logic [11:0]                   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // cpu ownership, triggers, indirect offset
  input  wire logic                          cpuNeedBus,
  input  wire logic [dma_pkg::TRIG_NUM-1:0]  trigSrc,
  input  wire logic [15:0]                   perOffset,
  // dma side of the peripheral and ram bus
  output logic      [15:0]                   busAddr,
  output logic      [15:0]                   busWrData,
  output logic      [1:0]                    busByteEn,
  output logic                               busRd,
  output logic                               busWr,
  input  wire logic [15:0]                   busRdData,
  // event pulses towards the interrupt controller
  output logic      [dma_pkg::NUM_CH-1:0]    chDoneEvt,
  output logic      [dma_pkg::NUM_CH-1:0]    halfEvt,
  output logic                               limitEvt
);

  localparam int NC = dma_pkg::NUM_CH;

  dma_pkg::dma_state_t s;
  dma_pkg::dma_state_t n;
  dma_pkg::chan_t      cs;
  dma_pkg::chan_t      rdCh;
  logic [NC-1:0]       ready;
  logic [NC-1:0]       trigHit;
  logic [NC-1:0]       swReq;
  logic [63:0]         trigAll;
  logic [2:0]          gnt;
  logic [2:0]          selIdx;
  logic [2:0]          rIdx;
  logic [2:0]          sub;
  logic [15:0]         srcEff;
  logic [15:0]         dstEff;
  logic [15:0]         srcNext;
  logic [15:0]         dstNext;
  logic [15:0]         cntDec;
  logic [15:0]         halfLvl;
  logic                srcFault;
  logic                dstFault;
  logic                acc;
  logic                wrEn;
  logic                hit;
  logic                chHit;
  logic [31:0]         rdVal;

  // lowest numbered requesting channel wins
  function automatic logic [2:0] pick(input logic [NC-1:0] r);
    pick = 3'h0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (r[i]) begin
        pick = 3'(i);
      end
    end
  endfunction

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  assign acc   = psel & penable;
  assign wrEn  = acc & s.pready & pwrite;
  assign chHit = (paddr >= dma_pkg::OFS_CH_BASE) && (paddr < dma_pkg::OFS_CH_END);
  assign rIdx  = 3'((paddr - dma_pkg::OFS_CH_BASE) >> dma_pkg::CH_SHIFT);
  assign sub   = paddr[4:2];

  // read mux; misaligned or unmapped words answer with slverr
  always_comb begin
    rdCh  = s.ch[rIdx];
    rdVal = 32'h0;
    hit   = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      if (chHit) begin
        hit = 1'b1;
        case (sub)
          dma_pkg::SUB_CTRL: rdVal = {21'h0, rdCh.ctrl[9:8], rdCh.pend, rdCh.ctrl[7:0]};
          dma_pkg::SUB_TRIG: rdVal = {26'h0, rdCh.trig};
          dma_pkg::SUB_SRC:  rdVal = {16'h0, rdCh.src};
          dma_pkg::SUB_DST:  rdVal = {16'h0, rdCh.dst};
          dma_pkg::SUB_CNT:  rdVal = {16'h0, rdCh.cnt};
          default:           hit   = 1'b0;
        endcase
      end else begin
        hit = 1'b1;
        case (paddr)
          dma_pkg::OFS_LIM_HI: rdVal = {16'h0, s.limHi};
          dma_pkg::OFS_LIM_LO: rdVal = {16'h0, s.limLo};
          dma_pkg::OFS_STATUS: rdVal = {10'h0, s.errFlag, 2'h0, s.halfFlag, 2'h0, s.doneFlag};
          dma_pkg::OFS_ACTIVE: rdVal = {28'h0, s.st != dma_pkg::ST_IDLE, s.act};
          default:             hit   = 1'b0;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // triggers and channel readiness
  // -----------------------------------------------------------------
  // completions re-enter as the top-priority sources, so channels chain
  assign trigAll = {1'b0, trigSrc | {{(dma_pkg::TRIG_NUM - NC){1'b0}}, s.doneEvt}}; // R08

  for (genvar g = 0; g < NC; g++) begin : g_ch
    assign ready[g]   = s.ch[g].ctrl.enable & s.ch[g].pend; // R01
    // select 0 reaches the constant bit 63, so it never fires
    assign trigHit[g] = trigAll[6'(dma_pkg::TRIG_NUM - int'(s.ch[g].trig))]; // R07
    assign swReq[g]   = wrEn & hit & chHit & (rIdx == 3'(g))
                      & (sub == dma_pkg::SUB_CTRL) & pwdata[dma_pkg::CTL_REQ]; // R20
  end

  assign gnt    = pick(ready); // R16
  assign selIdx = (s.st == dma_pkg::ST_IDLE) ? gnt : s.act;
  assign cs     = s.ch[selIdx];

  // -----------------------------------------------------------------
  // address generation for the channel in hand
  // -----------------------------------------------------------------
  dma_addr_unit u_src (
    .base     (cs.src),
    .mode     (cs.ctrl.srcMode),
    .byteSize (cs.ctrl.byteSize),
    .offset   (perOffset),
    .limLo    (s.limLo),
    .limHi    (s.limHi),
    .effAddr  (srcEff),
    .nextAddr (srcNext),
    .fault    (srcFault)
  );

  dma_addr_unit u_dst (
    .base     (cs.dst),
    .mode     (cs.ctrl.dstMode),
    .byteSize (cs.ctrl.byteSize),
    .offset   (perOffset),
    .limLo    (s.limLo),
    .limHi    (s.limHi),
    .effAddr  (dstEff),
    .nextAddr (dstNext),
    .fault    (dstFault)
  );

  assign cntDec  = 16'(cs.cnt - dma_pkg::CNT_ONE);
  assign halfLvl = {1'b0, cs.cntInit[15:1]};

  // -----------------------------------------------------------------
  // next state: software first, engine next, request sets last
  // -----------------------------------------------------------------
  always_comb begin
    n          = s;
    n.bus.rd   = 1'b0;
    n.bus.wr   = 1'b0;
    n.doneEvt  = '0;
    n.halfEvt  = '0;
    n.limitEvt = 1'b0;
    n.pready   = acc & ~s.pready;
    if (acc & ~s.pready) begin
      n.prdata  = rdVal;
      n.pslverr = ~hit;
    end
    // register writes land on the edge that sees pready high
    if (wrEn & hit) begin
      if (chHit) begin
        case (sub)
          dma_pkg::SUB_CTRL: n.ch[rIdx].ctrl = dma_pkg::chan_ctrl_t'({
            pwdata[dma_pkg::CTL_REQ+2:dma_pkg::CTL_REQ+1], pwdata[dma_pkg::CTL_REQ-1:0]});
          dma_pkg::SUB_TRIG: n.ch[rIdx].trig = pwdata[5:0];
          dma_pkg::SUB_SRC: begin
            n.ch[rIdx].src     = pwdata[15:0]; // R17
            n.ch[rIdx].srcInit = pwdata[15:0];
          end
          dma_pkg::SUB_DST: begin
            n.ch[rIdx].dst     = pwdata[15:0]; // R17
            n.ch[rIdx].dstInit = pwdata[15:0];
          end
          dma_pkg::SUB_CNT: begin
            n.ch[rIdx].cnt     = pwdata[15:0]; // R18
            n.ch[rIdx].cntInit = pwdata[15:0];
          end
          default: ;
        endcase
      end else begin
        case (paddr)
          dma_pkg::OFS_LIM_HI: n.limHi = pwdata[15:0]; // R22
          dma_pkg::OFS_LIM_LO: n.limLo = pwdata[15:0]; // R22
          dma_pkg::OFS_STATUS: begin
            n.doneFlag = s.doneFlag & ~pwdata[dma_pkg::STAT_DONE +: NC];
            n.halfFlag = s.halfFlag & ~pwdata[dma_pkg::STAT_HALF +: NC];
            n.errFlag  = s.errFlag & ~pwdata[dma_pkg::STAT_ERR +: NC];
          end
          default: ;
        endcase
      end
    end
    // engine; every bus access waits out a cpu claim first
    unique case (s.st)
      dma_pkg::ST_IDLE: begin
        if (|ready) begin
          n.act = gnt; // R16
          if (srcFault | dstFault) begin
            n.ch[gnt].ctrl.enable = 1'b0; // R04
            n.ch[gnt].pend        = 1'b0;
            n.errFlag[gnt]        = 1'b1;
            n.limitEvt            = 1'b1;
          end else begin
            n.st = dma_pkg::ST_READ; // R03
          end
        end
      end
      dma_pkg::ST_READ: begin
        if (!cpuNeedBus) begin
          n.bus.rd     = 1'b1; // R02
          n.bus.addr   = srcEff;
          n.bus.byteEn = cs.ctrl.byteSize ? (srcEff[0] ? dma_pkg::LANE_HI : dma_pkg::LANE_LO)
                                          : dma_pkg::LANE_BOTH; // R06
          n.st         = dma_pkg::ST_RDWAIT;
        end
      end
      dma_pkg::ST_RDWAIT: n.st = dma_pkg::ST_CAPT;
      dma_pkg::ST_CAPT: begin
        // a byte is kept in the low lane whichever lane it came from
        if (cs.ctrl.byteSize) begin
          n.data = {8'h0, srcEff[0] ? busRdData[15:8] : busRdData[7:0]}; // R05 R06
        end else begin
          n.data = busRdData;
        end
        n.st = dma_pkg::ST_WRITE;
      end
      dma_pkg::ST_WRITE: begin
        if (!cpuNeedBus) begin
          n.bus.wr     = 1'b1; // R02
          n.bus.addr   = dstEff;
          n.bus.wrData = cs.ctrl.byteSize ? {2{s.data[7:0]}} : s.data;
          n.bus.byteEn = cs.ctrl.byteSize ? (dstEff[0] ? dma_pkg::LANE_HI : dma_pkg::LANE_LO)
                                          : dma_pkg::LANE_BOTH; // R06
          n.st         = cs.ctrl.nullWr ? dma_pkg::ST_NULL : dma_pkg::ST_UPD;
        end
      end
      dma_pkg::ST_NULL: begin
        // dummy write of zero keeps a peripheral's buffers in step
        if (!cpuNeedBus) begin
          n.bus.wr     = 1'b1; // R21
          n.bus.addr   = srcEff;
          n.bus.wrData = 16'h0;
          // lane follows the source address, not the one left over from the real write
          n.bus.byteEn = cs.ctrl.byteSize ? (srcEff[0] ? dma_pkg::LANE_HI : dma_pkg::LANE_LO)
                                          : dma_pkg::LANE_BOTH; // R06
          n.st         = dma_pkg::ST_UPD;
        end
      end
      dma_pkg::ST_UPD: begin
        n.ch[s.act].src = srcNext; // R14 R17
        n.ch[s.act].dst = dstNext;
        n.ch[s.act].cnt = cntDec; // R18
        if ((cntDec == halfLvl) && (cs.cntInit > dma_pkg::CNT_ONE)) begin
          n.halfFlag[s.act] = 1'b1; // R19
          n.halfEvt[s.act]  = 1'b1;
        end
        // one-shot flavours consume the trigger per transaction
        if (!cs.ctrl.xferMode[1]) begin
          n.ch[s.act].pend = 1'b0; // R09 R11
        end
        if (cntDec == 16'h0) begin
          n.ch[s.act].pend   = 1'b0; // R10 R12
          n.doneFlag[s.act]  = 1'b1;
          n.doneEvt[s.act]   = 1'b1;
          if (cs.ctrl.reload | cs.ctrl.xferMode[0]) begin
            n.ch[s.act].src = cs.srcInit; // R13
            n.ch[s.act].dst = cs.dstInit;
            n.ch[s.act].cnt = cs.cntInit;
          end
          if (!cs.ctrl.xferMode[0]) begin
            n.ch[s.act].ctrl.enable = 1'b0; // R09 R10
          end
        end
        n.st = dma_pkg::ST_IDLE;
      end
      default: n.st = dma_pkg::ST_IDLE;
    endcase
    // a request arriving as the engine clears pend is kept
    for (int g = 0; g < NC; g++) begin
      if (swReq[g] | (trigHit[g] & n.ch[g].ctrl.enable)) begin
        n.ch[g].pend = 1'b1; // R07 R20
      end
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  // all-zero reset leaves every channel idle and in word size
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s       <= '0; // R05
      s.limHi <= dma_pkg::LIM_HI_RST;
      s.limLo <= dma_pkg::LIM_LO_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign busAddr   = s.bus.addr;
  assign busWrData = s.bus.wrData;
  assign busByteEn = s.bus.byteEn;
  assign busRd     = s.bus.rd;
  assign busWr     = s.bus.wr;
  assign chDoneEvt = s.doneEvt;
  assign halfEvt   = s.halfEvt;
  assign limitEvt  = s.limitEvt;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_YIELD: assert property ( // R02
    (busRd | busWr) |-> !$past(cpuNeedBus)
  ) else $error("dma bus access issued while the cpu claimed the bus");

  AST_LIMIT_ABORT: assert property ( // R04
    (s.st == dma_pkg::ST_IDLE && (|ready) && (srcFault | dstFault))
      |=> limitEvt && !s.ch[$past(gnt)].ctrl.enable && s.st == dma_pkg::ST_IDLE
  ) else $error("out-of-window access did not end the transaction");

  AST_WINDOW: assert property ( // R22
    ((busRd | busWr) && busAddr >= dma_pkg::RAM_START)
      |-> (busAddr >= s.limLo && busAddr <= s.limHi)
  ) else $error("ram access outside the limit window");

  AST_BYTE_LANE: assert property ( // R06
    ((busRd | busWr) && busByteEn != dma_pkg::LANE_BOTH)
      |-> busByteEn == (busAddr[0] ? dma_pkg::LANE_HI : dma_pkg::LANE_LO)
  ) else $error("byte lane does not follow address bit 0");

  AST_SW_REQ: assert property ( // R20
    (|swReq) |=> s.ch[$past(rIdx)].pend
  ) else $error("software request did not set the pending flag");

  AST_ONE_SHOT: assert property ( // R09
    (s.st == dma_pkg::ST_UPD && !cs.ctrl.xferMode[1] && !trigHit[s.act] && !swReq[s.act])
      |=> !s.ch[$past(s.act)].pend
  ) else $error("one-shot channel kept its request after a transaction");

  AST_CONT_HOLD: assert property ( // R10
    (s.st == dma_pkg::ST_UPD && cs.ctrl.xferMode[1] && cntDec != 16'h0)
      |=> s.ch[$past(s.act)].pend ##1 (s.st == dma_pkg::ST_READ || (|ready) || limitEvt)
  ) else $error("continuous channel dropped its series early");

  AST_COUNT: assert property ( // R18
    (s.st == dma_pkg::ST_UPD && cntDec != 16'h0 && !wrEn)
      |=> s.ch[$past(s.act)].cnt == $past(cntDec)
  ) else $error("transaction count did not step down by one");

  AST_RELOAD: assert property ( // R13
    (s.st == dma_pkg::ST_UPD && cntDec == 16'h0 && !wrEn
      && (cs.ctrl.reload | cs.ctrl.xferMode[0]))
      |=> s.ch[$past(s.act)].src == $past(cs.srcInit)
       && s.ch[$past(s.act)].cnt == $past(cs.cntInit)
  ) else $error("completion did not reload address and count");

  AST_HALF: assert property ( // R19
    (s.st == dma_pkg::ST_UPD && cntDec == halfLvl && cs.cntInit > dma_pkg::CNT_ONE)
      |=> halfEvt[$past(s.act)] ##1 halfEvt == '0
  ) else $error("half-count event missing or longer than one cycle");

  AST_PRIORITY: assert property ( // R16
    (s.st == dma_pkg::ST_IDLE && ready[0]) |=> s.act == 3'h0
  ) else $error("channel 0 request was not served first");

endmodule // dma_controller

// ===== sim/dma_mem_model.sv
`timescale 1ns/100ps
module dma_mem_model (
  // clock
  input  wire logic        core_clk,
  // engine side of the bus
  input  wire logic [15:0] busAddr,
  input  wire logic [15:0] busWrData,
  input  wire logic [1:0]  busByteEn,
  input  wire logic        busRd,
  input  wire logic        busWr,
  output logic      [15:0] busRdData
);
  logic [15:0] mem [0:32767];
  initial busRdData = 16'h0000;
  // -------------------------------------------------
  // word memory covering sfr and ram regions
  // -------------------------------------------------
  // data valid only the cycle after busRd; otherwise toggled so stale reads show
  always @(posedge core_clk) begin
    if (busRd) busRdData <= mem[busAddr[15:1]];
    else busRdData <= ~busRdData;
    if (busWr && busByteEn[0]) mem[busAddr[15:1]][7:0] <= busWrData[7:0];
    if (busWr && busByteEn[1]) mem[busAddr[15:1]][15:8] <= busWrData[15:8];
  end
endmodule // dma_mem_model

// ===== sim/multichannel_dma_controller_tb.sv
`timescale 1ns/100ps
module multichannel_dma_controller_tb;
  logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, busRd, busWr, limitEvt, lastErr, cpuNeedBus = 1'b0;
  logic [62:0] trigSrc = '0;
  logic [15:0] busAddr, busWrData, busRdData, perOffset = 16'h0000;
  logic [1:0]  busByteEn;
  logic [5:0]  chDoneEvt, halfEvt, halfSeen = 6'h00;
  int          error_cnt = 0, compares = 0;
  always #25 core_clk = ~core_clk;
  dma_controller dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuNeedBus(cpuNeedBus), .trigSrc(trigSrc), .perOffset(perOffset),
    .busAddr(busAddr), .busWrData(busWrData), .busByteEn(busByteEn), .busRd(busRd),
    .busWr(busWr), .busRdData(busRdData), .chDoneEvt(chDoneEvt), .halfEvt(halfEvt),
    .limitEvt(limitEvt));
  dma_mem_model mem (.core_clk(core_clk), .busAddr(busAddr), .busWrData(busWrData),
    .busByteEn(busByteEn), .busRd(busRd), .busWr(busWr), .busRdData(busRdData));
  // sticky record of half-count pulses; skips the unknowns before reset takes hold
  always @(posedge core_clk) if (!rst) halfSeen <= halfSeen | halfEvt;
  // -------------------------------------------------
  // apb master, comparison and closing tasks
  // -------------------------------------------------
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    lastErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait on done or limit pulses, mask {limit, done[5:0]}
  task automatic wait_ev(input logic [6:0] m);
    int i;
    for (i = 0; i < 300 && (({limitEvt, chDoneEvt} & m) == 7'h00); i++) @(posedge core_clk);
    chk("event", {25'h0, m & {limitEvt, chDoneEvt}}, {25'h0, m});
  endtask
  // channel setup: trigger select, source, destination, count, then control
  task automatic setup(input int c, input logic [15:0] t, s, d, n, k);
    logic [11:0] b;
    b = 12'h020 + 12'(c * 32);
    apb(b + 12'h004, 1'b1, {16'h0, t});
    apb(b + 12'h008, 1'b1, {16'h0, s});
    apb(b + 12'h00C, 1'b1, {16'h0, d});
    apb(b + 12'h010, 1'b1, {16'h0, n});
    apb(b, 1'b1, {16'h0, k});
  endtask
  // -------------------------------------------------
  // watchdog and main sequence
  // -------------------------------------------------
  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
  initial begin
    mem.mem[16'h0080] = 16'h1234;
    mem.mem[16'h0081] = 16'h5678;
    mem.mem[16'h0480] = 16'hAB12;
    mem.mem[16'h0481] = 16'hC0DE;
    mem.mem[16'h0508] = 16'h0000;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    apb(12'h000, 1'b0, 32'h0); chk("upper limit", rv, 32'h0000FFFF);
    apb(12'h004, 1'b0, 32'h0); chk("lower limit", rv, 32'h00000800);
    apb(12'h020, 1'b0, 32'h0); chk("ctrl reset", rv, 32'h0);
    apb(12'h0F0, 1'b0, 32'h0); chk("unmapped", {31'h0, lastErr}, 32'h1);
    // sfr to ram, continuous, both increment, software start, cpu steals bus
    setup(0, 16'h0000, 16'h0100, 16'h0A00, 16'h0002, 16'h0159);
    cpuNeedBus <= 1'b1;
    repeat (3) @(posedge core_clk);
    cpuNeedBus <= 1'b0;
    wait_ev(7'h01);
    chk("dst w0", {16'h0, mem.mem[16'h0500]}, 32'h1234);
    chk("dst w1", {16'h0, mem.mem[16'h0501]}, 32'h5678);
    apb(12'h028, 1'b0, 32'h0); chk("live src", rv, 32'h0104);
    apb(12'h030, 1'b0, 32'h0); chk("live cnt", rv, 32'h0);
    apb(12'h008, 1'b0, 32'h0); chk("done half", rv & 32'h101, 32'h101);
    chk("half evt", {26'h0, halfSeen}, 32'h1);
    // byte move, odd source picks upper lane, even destination lower lane
    setup(2, 16'h0000, 16'h0901, 16'h0A10, 16'h0001, 16'h0103);
    wait_ev(7'h04);
    chk("byte lane", {16'h0, mem.mem[16'h0508]}, 32'h00AB);
    // hardware trigger select 1 drives from the last source line
    setup(3, 16'h0001, 16'h0902, 16'h0A20, 16'h0001, 16'h0001);
    trigSrc[62] <= 1'b1;
    @(posedge core_clk);
    trigSrc[62] <= 1'b0;
    wait_ev(7'h08);
    chk("trig copy", {16'h0, mem.mem[16'h0510]}, 32'hC0DE);
    // done of channel 4 cascades into channel 5 through trigger select 59
    setup(5, 16'h003B, 16'h0902, 16'h0A50, 16'h0001, 16'h0001);
    // indirect source plus null write; repeated one-shot stays armed and reloads
    perOffset <= 16'h0002;
    setup(4, 16'h0000, 16'h0100, 16'h0A40, 16'h0001, 16'h05C5);
    wait_ev(7'h10);
    wait_ev(7'h20);
    chk("cascade", {16'h0, mem.mem[16'h0528]}, 32'hC0DE);
    chk("indirect", {16'h0, mem.mem[16'h0520]}, 32'h5678);
    chk("null write", {16'h0, mem.mem[16'h0081]}, 32'h0);
    apb(12'h0A0, 1'b0, 32'h0); chk("rearmed", rv, 32'h04C5);
    apb(12'h0B0, 1'b0, 32'h0); chk("reload", rv, 32'h1);
    // raised lower limit puts the source outside the window
    apb(12'h004, 1'b1, 32'h00001000);
    setup(1, 16'h0000, 16'h0900, 16'h0A30, 16'h0001, 16'h0101);
    wait_ev(7'h40);
    apb(12'h008, 1'b0, 32'h0); chk("err flag", rv[21:16], 32'h02);
    apb(12'h040, 1'b0, 32'h0); chk("enable off", rv & 32'h1, 32'h0);
    test_done();
  end
endmodule // multichannel_dma_controller_tb
